/* src/operator_panel_io_logic.sv */
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
// Contract
// RULE_01: three indicator bars green, yellow, red, each with on and blink bit.
// RULE_02: an indicator lights while its on bit is one, dark when zero.
// RULE_03: blink bit set on a lit indicator makes it flash until cleared.
// RULE_04: five pushbuttons, each with type, state, lamp bit and blink bit.
// RULE_05: decouple off (default): each lamp mirrors its button state.
// RULE_06: decouple on: lamp follows only its own lamp output bit.
// RULE_07: decouple acts only on hold-type buttons; toggle lamps mirror state.
// RULE_08: hold-type button reports on only while pressed.
// RULE_09: toggle-type button inverts its state once per press.
// RULE_10: controller never writes button state; uses turn-on/turn-off commands.
// RULE_11: lamp blink only on a lit lamp, under decoupling, hold-type button.
// RULE_12: two display lines, top 1 and bottom 2, 20 characters each.
// RULE_13: lines update independently; text never spills to the other line.
// RULE_14: enter keypress stores the keyed value as a 32-bit real input.
// RULE_15: same enter keypress sets the data-ready bit.
// RULE_16: all flashing uses one shared divider rate.
// RULE_17: data-ready stays until controller clears it; new enter reloads it.
module operator_panel_io_logic
  import panel_pkg::*;
#(
  parameter int BLINK_DIV = BLINK_CYCLES
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [NUM_BTN-1:0]   btn_press,
  input  wire logic                 key_enter,
  input  wire logic [31:0]          key_value,
  output lamp_drive_t               lamp_out,
  output logic [LINE_BITS-1:0]      line1_text,
  output logic [LINE_BITS-1:0]      line2_text,
  output logic                      irq
);

  // ======================================================================
  // pin synchronisers
  logic [NUM_BTN-1:0] press_s1_r;
  logic [NUM_BTN-1:0] press_s2_r;
  logic [NUM_BTN-1:0] press_d_r;
  logic               enter_s1_r;
  logic               enter_s2_r;
  logic               enter_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_s1_r <= '0;
      press_s2_r <= '0;
      press_d_r  <= '0;
      enter_s1_r <= 1'b0;
      enter_s2_r <= 1'b0;
      enter_d_r  <= 1'b0;
    end else begin
      press_s1_r <= btn_press;
      press_s2_r <= press_s1_r;
      press_d_r  <= press_s2_r;
      enter_s1_r <= key_enter;
      enter_s2_r <= enter_s1_r;
      enter_d_r  <= enter_s2_r;
    end
  end

  wire [NUM_BTN-1:0] press_rise = press_s2_r & ~press_d_r;
  wire               enter_rise = enter_s2_r & ~enter_d_r;

  // ======================================================================
  // ahb-lite slave
  logic        dp_wr_r;
  logic        dp_rd_r;
  logic [11:0] dp_addr_r;

  wire addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_rd_r   <= 1'b0;
      dp_addr_r <= '0;
    end else begin
      dp_wr_r   <= addr_ok & hwrite;
      dp_rd_r   <= addr_ok & ~hwrite;
      dp_addr_r <= addr_ok ? haddr[11:0] : dp_addr_r;
    end
  end

  wire wr_ctrl  = dp_wr_r & (dp_addr_r == OFS_CTRL);
  wire wr_cmd   = dp_wr_r & (dp_addr_r == OFS_BTN_CMD);
  wire wr_rdy   = dp_wr_r & (dp_addr_r == OFS_DATA_RDY);
  wire wr_irqen = dp_wr_r & (dp_addr_r == OFS_IRQ_EN);
  wire wr_irqcl = dp_wr_r & (dp_addr_r == OFS_IRQ_CLR);
  wire wr_line1 = dp_wr_r & (dp_addr_r >= OFS_LINE1) &
                  (dp_addr_r < OFS_LINE1 + OFS_LINE_SPAN);
  wire wr_line2 = dp_wr_r & (dp_addr_r >= OFS_LINE2) &
                  (dp_addr_r < OFS_LINE2 + OFS_LINE_SPAN);
  wire [2:0] line_idx1 = 3'((dp_addr_r - OFS_LINE1) >> 2);
  wire [2:0] line_idx2 = 3'((dp_addr_r - OFS_LINE2) >> 2);

  // ======================================================================
  // control and state registers
  logic [31:0]         ctrl_r;
  logic [NUM_BTN-1:0]  btn_state_r;
  logic [NUM_BTN-1:0]  btn_state_nxt;
  key_entry_t          entry_r;
  logic [IRQ_BITS-1:0] irq_stat_r;
  logic [IRQ_BITS-1:0] irq_en_r;
  logic [31:0]         line1_r [LINE_WORDS];
  logic [31:0]         line2_r [LINE_WORDS];

  wire [NUM_IND-1:0] ind_on     = ctrl_r[CTRL_IND_ON +: NUM_IND];
  wire [NUM_IND-1:0] ind_blink  = ctrl_r[CTRL_IND_BLINK +: NUM_IND];
  wire [NUM_BTN-1:0] lamp_bit   = ctrl_r[CTRL_LAMP_ON +: NUM_BTN];
  wire [NUM_BTN-1:0] lamp_blink = ctrl_r[CTRL_LAMP_BLK +: NUM_BTN];
  wire [NUM_BTN-1:0] btn_type   = ctrl_r[CTRL_BTN_TYPE +: NUM_BTN];
  wire               decouple   = ctrl_r[CTRL_DECOUPLE];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata;
    end
  end

  // button state: hold follows press, toggle flips per press, commands override
  wire [NUM_BTN-1:0] cmd_on  = wr_cmd ? hwdata[CMD_ON +: NUM_BTN] : '0; // RULE_10
  wire [NUM_BTN-1:0] cmd_off = wr_cmd ? hwdata[CMD_OFF +: NUM_BTN] : '0; // RULE_10

  always_comb begin
    for (int i = 0; i < NUM_BTN; i++) begin
      if (btn_type[i] == BTN_TOGGLE) begin
        btn_state_nxt[i] = btn_state_r[i] ^ press_rise[i]; // RULE_09
      end else begin
        btn_state_nxt[i] = press_s2_r[i]; // RULE_08
      end
      if (cmd_on[i]) begin
        btn_state_nxt[i] = 1'b1;
      end else if (cmd_off[i]) begin
        btn_state_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      btn_state_r <= '0;
    end else begin
      btn_state_r <= btn_state_nxt; // RULE_04
    end
  end

  // keyed entry: set on enter wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_r <= '0;
    end else if (enter_rise) begin
      entry_r.value <= key_value; // RULE_14
      entry_r.valid <= 1'b1;      // RULE_15 RULE_17
    end else if (wr_rdy && hwdata[0] == 1'b0) begin
      entry_r.valid <= 1'b0;      // RULE_17
    end
  end

  // line text storage, one word per 4 characters
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int w = 0; w < LINE_WORDS; w++) begin
        line1_r[w] <= LINE_RESET;
        line2_r[w] <= LINE_RESET;
      end
    end else begin
      if (wr_line1) begin
        line1_r[line_idx1] <= hwdata; // RULE_13
      end
      if (wr_line2) begin
        line2_r[line_idx2] <= hwdata; // RULE_13
      end
    end
  end

  // ======================================================================
  // interrupts
  wire [IRQ_BITS-1:0] irq_evt = {|(btn_state_nxt ^ btn_state_r), enter_rise};
  wire [IRQ_BITS-1:0] irq_clr = wr_irqcl ? hwdata[IRQ_BITS-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= '0;
      irq_en_r   <= '0;
      irq        <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (wr_irqen) begin
        irq_en_r <= hwdata[IRQ_BITS-1:0];
      end
      irq <= |(((irq_stat_r & ~irq_clr) | irq_evt) &
               (wr_irqen ? hwdata[IRQ_BITS-1:0] : irq_en_r));
    end
  end

  // ======================================================================
  // shared blink divider
  logic [31:0] blink_cnt_r;
  logic        blink_phase_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_r   <= '0;
      blink_phase_r <= 1'b1;
    end else if (blink_cnt_r == 32'(BLINK_DIV - 1)) begin
      blink_cnt_r   <= '0;
      blink_phase_r <= ~blink_phase_r; // RULE_16
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  // ======================================================================
  // lamp drive
  wire [NUM_BTN-1:0] sep = {NUM_BTN{decouple}} & ~btn_type; // RULE_07
  wire [NUM_BTN-1:0] lamp_lit = (sep & lamp_bit) | (~sep & btn_state_nxt); // RULE_05 RULE_06
  wire [NUM_BTN-1:0] lamp_flash = sep & lamp_bit & lamp_blink; // RULE_11
  wire [NUM_IND-1:0] ind_flash = ind_on & ind_blink; // RULE_03
  lamp_drive_t       drive_nxt;

  assign drive_nxt.ind  = ind_on & ~(ind_flash & {NUM_IND{~blink_phase_r}}); // RULE_01 RULE_02
  assign drive_nxt.lamp = lamp_lit & ~(lamp_flash & {NUM_BTN{~blink_phase_r}});

  // ======================================================================
  // outputs and read mux
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (dp_addr_r)
      OFS_CTRL:      rd_nxt = ctrl_r;
      OFS_BTN_STATE: rd_nxt = 32'(btn_state_r);
      OFS_DATA_VAL:  rd_nxt = entry_r.value;
      OFS_DATA_RDY:  rd_nxt = 32'(entry_r.valid);
      OFS_IRQ_STAT:  rd_nxt = 32'(irq_stat_r);
      OFS_IRQ_EN:    rd_nxt = 32'(irq_en_r);
      default: begin
        if (dp_addr_r >= OFS_LINE1 && dp_addr_r < OFS_LINE1 + OFS_LINE_SPAN) begin
          rd_nxt = line1_r[line_idx1];
        end else if (dp_addr_r >= OFS_LINE2 && dp_addr_r < OFS_LINE2 + OFS_LINE_SPAN) begin
          rd_nxt = line2_r[line_idx2];
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata     <= '0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      lamp_out   <= '0;
      line1_text <= {LINE_WORDS{LINE_RESET}};
      line2_text <= {LINE_WORDS{LINE_RESET}};
    end else begin
      // read data lands after one wait state
      hrdata    <= dp_rd_r ? rd_nxt : hrdata;
      hreadyout <= ~(addr_ok & ~hwrite);
      hresp     <= 1'b0;
      lamp_out  <= drive_nxt;
      for (int w = 0; w < LINE_WORDS; w++) begin
        line1_text[w*32 +: 32] <= line1_r[w]; // RULE_12
        line2_text[w*32 +: 32] <= line2_r[w]; // RULE_12
      end
    end
  end

  // reads insert one wait state, so a write just before is already visible
  // hrdata holds its last word between reads

  // ======================================================================
  // checks
  AST_IND_DARK: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    !ind_on[IND_GREEN] |=> !lamp_out.ind[IND_GREEN])
    else $error("indicator lit while off");
  AST_IND_STEADY: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    (ind_on[IND_RED] && !ind_blink[IND_RED]) |=> lamp_out.ind[IND_RED])
    else $error("steady indicator not lit");
  AST_MIRROR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    !decouple |=> lamp_out.lamp == $past(btn_state_nxt))
    else $error("lamp not mirroring button");
  AST_TOGGLE_MIRROR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    (btn_type[0] == BTN_TOGGLE) |=> lamp_out.lamp[0] == btn_state_r[0])
    else $error("toggle lamp decoupled");
  AST_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    (btn_type[1] == BTN_HOLD && !wr_cmd) |=> btn_state_r[1] == $past(press_s2_r[1]))
    else $error("hold button mismatch");
  AST_TOGGLE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    (btn_type[1] == BTN_TOGGLE && press_rise[1] && !wr_cmd)
    |=> btn_state_r[1] != $past(btn_state_r[1]))
    else $error("toggle did not flip");
  AST_ENTER: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
    enter_rise |=> entry_r.valid && entry_r.value == $past(key_value))
    else $error("entry not captured");
  AST_READY_HOLD: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    (entry_r.valid && !wr_rdy) |=> entry_r.valid)
    else $error("ready dropped without clear");
  AST_BLINK_LIT: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    (!sep[3]) |=> lamp_out.lamp[3] == $past(btn_state_nxt[3]))
    else $error("blink applied outside decoupling");
  AST_YELLOW_DARK: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    !ind_on[IND_YELLOW] |=> !lamp_out.ind[IND_YELLOW])
    else $error("yellow indicator lit while off");
  AST_IND_FLASH: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    (ind_on[IND_GREEN] && ind_blink[IND_GREEN] && !blink_phase_r) |=> !lamp_out.ind[IND_GREEN])
    else $error("flashing indicator not dark in off phase");
  AST_DECOUPLE_LAMP: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    (sep[4] && !lamp_bit[4]) |=> !lamp_out.lamp[4])
    else $error("decoupled lamp lit without lamp bit");
  AST_TOGGLE_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    (btn_type[1] == BTN_TOGGLE && !press_rise[1] && !wr_cmd)
    |=> btn_state_r[1] == $past(btn_state_r[1]))
    else $error("toggle changed without press");
  AST_LAMP_FLASH: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    (sep[0] && lamp_bit[0] && lamp_blink[0] && !blink_phase_r) |=> !lamp_out.lamp[0])
    else $error("flashing lamp not dark in off phase");
  AST_LINE_APART: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
    wr_line1 |=> line2_r[0] == $past(line2_r[0]))
    else $error("line 1 write disturbed line 2");
  AST_ENTER_IRQ: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
    enter_rise |=> irq_stat_r[IRQ_ENTER])
    else $error("enter did not raise status");
  AST_READY_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    (wr_rdy && !hwdata[0] && !enter_rise) |=> !entry_r.valid)
    else $error("ready not cleared by controller");
  AST_BLINK_RANGE: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
    blink_cnt_r < 32'(BLINK_DIV))
    else $error("blink divider out of range");

endmodule

/* src/panel_pkg.sv */
package panel_pkg;

  // ======================================================================
  // sizes
  localparam int NUM_IND       = 3;
  localparam int NUM_BTN       = 5;
  localparam int LINE_CHARS    = 20;
  localparam int LINE_BITS     = LINE_CHARS * 8;
  localparam int LINE_WORDS    = LINE_CHARS / 4;
  localparam int IND_GREEN     = 0;
  localparam int IND_YELLOW    = 1;
  localparam int IND_RED       = 2;

  // ======================================================================
  // register byte offsets
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_BTN_STATE = 12'h004;
  localparam logic [11:0] OFS_BTN_CMD   = 12'h008;
  localparam logic [11:0] OFS_DATA_VAL  = 12'h00C;
  localparam logic [11:0] OFS_DATA_RDY  = 12'h010;
  localparam logic [11:0] OFS_IRQ_STAT  = 12'h014;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h018;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h01C;
  localparam logic [11:0] OFS_LINE1     = 12'h040;
  localparam logic [11:0] OFS_LINE2     = 12'h060;
  localparam logic [11:0] OFS_LINE_SPAN = 12'h014;

  // ======================================================================
  // ctrl field positions
  localparam int CTRL_IND_ON    = 0;
  localparam int CTRL_IND_BLINK = 4;
  localparam int CTRL_LAMP_ON   = 8;
  localparam int CTRL_LAMP_BLK  = 16;
  localparam int CTRL_BTN_TYPE  = 24;
  localparam int CTRL_DECOUPLE  = 31;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LINE_RESET = 32'h2020_2020;

  // btn_cmd: [4:0] turn on, [12:8] turn off
  localparam int CMD_ON  = 0;
  localparam int CMD_OFF = 8;

  // irq bits
  localparam int IRQ_ENTER  = 0;
  localparam int IRQ_BTN    = 1;
  localparam int IRQ_BITS   = 2;

  // ======================================================================
  // timing
  localparam int  CLK_HZ        = 40_000_000;
  localparam int  BLINK_HALF_MS = 250;
  localparam int  BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_HALF_MS;

  // ======================================================================
  // htrans codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic [NUM_IND-1:0] ind;
    logic [NUM_BTN-1:0] lamp;
  } lamp_drive_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } key_entry_t;

  typedef enum logic {
    BTN_HOLD   = 1'b0,
    BTN_TOGGLE = 1'b1
  } btn_type_t;

endpackage

/* testbench/ahb_host.sv */
`timescale 1ns/10ps
module ahb_host
  import panel_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ======================================================================
  // single word transfer
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    // released lines show no stale value
    hsel   <= 1'b0;
    haddr  <= ~a;
    hwdata <= ~d;
  endtask
endmodule

/* testbench/operator_panel_io_logic_test.sv */
`timescale 1ns/10ps
module operator_panel_io_logic_test;
  import panel_pkg::*;
  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [NUM_BTN-1:0]   btn_press;
  logic                 key_enter;
  logic [31:0]          key_value;
  lamp_drive_t          lamp_out;
  logic [LINE_BITS-1:0] line1_text;
  logic [LINE_BITS-1:0] line2_text;
  logic                 irq;
  logic [7:0]           lo;
  int                   n_fail;
  int                   checked;
  int                   n;
  logic [31:0]          c;
  assign lo = lamp_out;

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  operator_panel_io_logic #(.BLINK_DIV(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .btn_press(btn_press),
    .key_enter(key_enter), .key_value(key_value), .lamp_out(lamp_out),
    .line1_text(line1_text), .line2_text(line2_text), .irq(irq));

  ahb_host i_host (
    .hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ======================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, {20'h0, a}, d, q);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, {20'h0, a}, 32'h0, q);
    chk(nm, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic settle;
    repeat (6) @(posedge hclk);
    #1;
  endtask
  task automatic set_btn(input int b, input logic v);
    @(posedge hclk);
    btn_press[b] <= v;
    settle;
  endtask
  task automatic pulse(input int b);
    set_btn(b, 1'b1);
    set_btn(b, 1'b0);
  endtask
  task automatic enter(input logic [31:0] v);
    @(posedge hclk);
    key_value <= v;
    key_enter <= 1'b1;
    settle;
    @(posedge hclk);
    key_enter <= 1'b0;
    settle;
  endtask
  // counts output changes over 20 cycles
  task automatic blink(input int i, output int k);
    logic p;
    k = 0;
    @(posedge hclk);
    #1;
    p = lo[i];
    repeat (20) begin
      @(posedge hclk);
      #1;
      if (lo[i] !== p) k++;
      p = lo[i];
    end
  endtask
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic conclude;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    conclude;
  end

  // ======================================================================
  // tests
  initial begin
    n_fail = 0;
    checked = 0;
    hresetn = 1'b0;
    btn_press = '0;
    key_enter = 1'b0;
    key_value = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    settle;
    chk("lamps", 32'h0, {24'h0, lo});
    chk("line2 w4", LINE_RESET, line2_text[159:128]);
    rdc("ctrl", OFS_CTRL, CTRL_RESET);
    tend("reset");
    wr(OFS_CTRL, 32'h5 << CTRL_IND_ON);
    settle;
    chk("ind", 32'h5, {29'h0, lamp_out.ind});
    wr(OFS_CTRL, 32'h3 << CTRL_IND_ON);
    settle;
    chk("ind", 32'h3, {29'h0, lamp_out.ind});
    wr(OFS_CTRL, (32'h3 << CTRL_IND_ON) | (32'h1 << CTRL_IND_BLINK));
    blink(5, n);
    chk("green blink", 32'h1, {31'h0, n > 1});
    blink(6, n);
    chk("yellow steady", 32'h0, n);
    wr(OFS_CTRL, 32'h1 << CTRL_IND_BLINK);
    blink(5, n);
    chk("dark no blink", 32'h0, n + lo[5]);
    tend("indicators");
    wr(OFS_CTRL, CTRL_RESET);
    for (int b = 0; b < NUM_BTN; b++) begin
      set_btn(b, 1'b1);
      chk("hold lamp", 32'h1 << b, {27'h0, lamp_out.lamp});
      rdc("hold state", OFS_BTN_STATE, 32'h1 << b);
      set_btn(b, 1'b0);
      rdc("released", OFS_BTN_STATE, 32'h0);
    end
    wr(OFS_CTRL, 32'h1 << (CTRL_BTN_TYPE + 1));
    pulse(1);
    rdc("toggle on", OFS_BTN_STATE, 32'h2);
    pulse(1);
    rdc("toggle off", OFS_BTN_STATE, 32'h0);
    wr(OFS_BTN_CMD, 32'h2 << CMD_ON);
    rdc("cmd on", OFS_BTN_STATE, 32'h2);
    wr(OFS_BTN_CMD, 32'h2 << CMD_OFF);
    rdc("cmd off", OFS_BTN_STATE, 32'h0);
    rdc("irq btn", OFS_IRQ_STAT, 32'h1 << IRQ_BTN);
    tend("buttons");
    c = (32'h1 << CTRL_DECOUPLE) | (32'h1 << (CTRL_BTN_TYPE + 1)) | (32'h1 << CTRL_LAMP_ON);
    wr(OFS_CTRL, c);
    pulse(1);
    set_btn(2, 1'b1);
    chk("decoupled", 32'h3, {27'h0, lamp_out.lamp});
    rdc("state", OFS_BTN_STATE, 32'h6);
    set_btn(2, 1'b0);
    wr(OFS_CTRL, c | (32'h7 << CTRL_LAMP_BLK));
    blink(0, n);
    chk("lamp blink", 32'h1, {31'h0, n > 1});
    blink(1, n);
    chk("toggle no blink", 32'h0, n);
    blink(2, n);
    chk("unlit no blink", 32'h0, n + lo[2]);
    wr(OFS_BTN_CMD, 32'h2 << CMD_OFF);
    wr(OFS_CTRL, CTRL_RESET);
    tend("decouple");
    wr(OFS_LINE1, 32'h4443_4241);
    wr(OFS_LINE1 + 12'h010, 32'h5A59_5857);
    wr(OFS_LINE1 + OFS_LINE_SPAN, 32'h3131_3131);
    wr(OFS_LINE2 + 12'h004, 32'h3433_3231);
    settle;
    chk("l1 w0", 32'h4443_4241, line1_text[31:0]);
    chk("l1 w4", 32'h5A59_5857, line1_text[159:128]);
    chk("l1 w1", LINE_RESET, line1_text[63:32]);
    chk("l2 w0", LINE_RESET, line2_text[31:0]);
    chk("l2 w1", 32'h3433_3231, line2_text[63:32]);
    rdc("l1 rd", OFS_LINE1 + 12'h010, 32'h5A59_5857);
    tend("lines");
    wr(OFS_IRQ_CLR, 32'h3);
    wr(OFS_IRQ_EN, 32'h1 << IRQ_ENTER);
    enter(32'h3FC0_0000);
    rdc("value", OFS_DATA_VAL, 32'h3FC0_0000);
    rdc("ready", OFS_DATA_RDY, 32'h1);
    rdc("irq stat", OFS_IRQ_STAT, 32'h1 << IRQ_ENTER);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_CLR, 32'h1 << IRQ_ENTER);
    settle;
    chk("irq clr", 32'h0, {31'h0, irq});
    rdc("still ready", OFS_DATA_RDY, 32'h1);
    wr(OFS_DATA_RDY, 32'h0);
    rdc("acked", OFS_DATA_RDY, 32'h0);
    enter(32'hC120_0000);
    rdc("new value", OFS_DATA_VAL, 32'hC120_0000);
    rdc("ready again", OFS_DATA_RDY, 32'h1);
    rdc("unmapped", 12'h100, 32'h0);
    tend("entry");
    conclude;
  end
endmodule
